/* File: logic/eeprom_host_pkg.sv */
// Shared types and timing constants for the paged EEPROM host controller
package eeprom_host_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int WP_NS = 100;
  localparam int WPH_NS = 50;
  localparam int ACC_NS = 120;
  localparam int CEPH_NS = 50;
  localparam int OEHP_NS = 150;
  localparam int BLC_US = 150;
  localparam int TWC_MS = 10;
  localparam int SYNC_CYC = 3;
  // Least times round up, the two longest times (BLC and TWC) round down
  localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CEPH_CYC = (CEPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_CYC = (OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLC_CYC = (BLC_US * 1000) / CLK_NS;
  localparam int TWC_CYC = (TWC_MS * 1000000) / CLK_NS;
  // Margin covers accept cycle plus the strobe ahead of the rising edge
  localparam int LOAD_LIM = BLC_CYC - 4;
  localparam int PAGE_BYTES = 128;
  localparam int PROT_LEN = 3;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam int PAGE_LSB = 7;
  localparam int ADDR_W = 17;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [11:0] WIN_RST = 12'h000;
  localparam logic [23:0] TMO_RST = 24'h000000;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_PROT_ON = 2'h2,
    OP_PROT_OFF = 2'h3
  } op_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WLOW = 6'h02,
    ST_WHIGH = 6'h04,
    ST_LOAD = 6'h08,
    ST_RLOW = 6'h10,
    ST_RHIGH = 6'h20
  } state_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic last;
  } cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic err;
  } rsp_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic ce_b;
    logic oe_b;
    logic we_b;
  } pin_out_s;

endpackage : eeprom_host_pkg

/* File: logic/eeprom_host.sv */
// Host controller driving a paged parallel EEPROM through its pins
`timescale 1ns/1ns
`default_nettype none
module eeprom_host #(
  parameter int TWC_LIM = eeprom_host_pkg::TWC_CYC,
  // Command byte addresses and values; values here are arbitrary
  parameter logic [16:0] PON_A0 = 17'h00001,
  parameter logic [16:0] PON_A1 = 17'h00002,
  parameter logic [16:0] PON_A2 = 17'h00003,
  parameter logic [7:0] PON_D0 = 8'h11,
  parameter logic [7:0] PON_D1 = 8'h22,
  parameter logic [7:0] PON_D2 = 8'h33,
  parameter logic [16:0] POFF_A0 = 17'h00001,
  parameter logic [16:0] POFF_A1 = 17'h00002,
  parameter logic [16:0] POFF_A2 = 17'h00003,
  parameter logic [7:0] POFF_D0 = 8'h11,
  parameter logic [7:0] POFF_D1 = 8'h22,
  parameter logic [7:0] POFF_D2 = 8'h44
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Command port
  input wire logic CMD_VALID,
  input wire eeprom_host_pkg::cmd_s CMD,
  output logic CMD_READY,
  // Answer port
  output logic RSP_VALID,
  output eeprom_host_pkg::rsp_s RSP,
  output logic BUSY,
  // Memory pins
  output eeprom_host_pkg::pin_out_s PIN,
  input wire logic [7:0] DQ_IN
);
  import eeprom_host_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_e st;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic ce_b;
    logic oe_b;
    logic we_b;
    logic dq_oe;
    logic [3:0] cnt;
    logic [11:0] win;
    logic [23:0] tmo;
    logic [7:0] nbytes;
    logic [1:0] seq;
    logic prot_on;
    logic poll;
    logic have_prev;
    logic prev6;
    logic last;
    logic rsp_valid;
    rsp_s rsp;
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [7:0] sy3;
  } regs_s;

  regs_s r_q;
  regs_s r_d;
  logic page_ok;
  logic [ADDR_W-1:0] seq_addr;
  logic [7:0] seq_data;

  // ----------------------------------------------------------------
  // Protection command table
  // ----------------------------------------------------------------
  always_comb begin
    unique case (r_q.seq)
      2'h0: begin
        seq_addr = r_q.prot_on ? PON_A1 : POFF_A1;
        seq_data = r_q.prot_on ? PON_D1 : POFF_D1;
      end
      2'h1: begin
        seq_addr = r_q.prot_on ? PON_A2 : POFF_A2;
        seq_data = r_q.prot_on ? PON_D2 : POFF_D2;
      end
      default: begin
        seq_addr = r_q.prot_on ? PON_A0 : POFF_A0;
        seq_data = r_q.prot_on ? PON_D0 : POFF_D0;
      end
    endcase
  end

  // A new byte joins the open page only on the same page lines
  assign page_ok = CMD.op == OP_WRITE && r_q.nbytes < 8'(PAGE_BYTES) &&
                   CMD.addr[ADDR_W-1:PAGE_LSB] ==
                   r_q.addr[ADDR_W-1:PAGE_LSB];

  // Busy while polling blocks every new access
  assign CMD_READY = r_q.st == ST_IDLE ||
                     (r_q.st == ST_LOAD && page_ok);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.rsp_valid = 1'b0;
    r_d.sy1 = DQ_IN;
    r_d.sy2 = r_q.sy1;
    r_d.sy3 = r_q.sy2;
    if (r_q.poll) begin
      r_d.tmo = r_q.tmo + 24'h000001;
    end
    unique case (r_q.st)
      ST_IDLE: begin
        r_d.ce_b = 1'b1;
        r_d.we_b = 1'b1;
        r_d.oe_b = 1'b1;
        r_d.dq_oe = 1'b0;
        if (CMD_VALID) begin
          r_d.nbytes = 8'h00;
          r_d.last = CMD.last;
          r_d.seq = 2'h0;
          r_d.addr = CMD.addr;
          r_d.wdata = CMD.data;
          if (CMD.op == OP_READ) begin
            r_d.st = ST_RLOW;
            r_d.ce_b = 1'b0;
            r_d.oe_b = 1'b0;
            r_d.cnt = 4'(ACC_CYC + SYNC_CYC - 1);
          end else begin
            // Command bytes go first for either protection op
            r_d.seq = (CMD.op == OP_WRITE) ? 2'h3 : 2'h0;
            r_d.prot_on = CMD.op == OP_PROT_ON;
            r_d.last = (CMD.op == OP_WRITE) ? CMD.last : 1'b0;
            r_d.st = ST_WLOW;
            r_d.ce_b = 1'b0;
            r_d.we_b = 1'b0;
            r_d.oe_b = 1'b1;
            r_d.dq_oe = 1'b1;
            r_d.cnt = 4'(WP_CYC - 1);
            if (CMD.op != OP_WRITE) begin
              r_d.addr = CMD.op == OP_PROT_ON ? PON_A0 : POFF_A0;
              r_d.wdata = CMD.op == OP_PROT_ON ? PON_D0 : POFF_D0;
            end
          end
        end
      end
      ST_WLOW: begin
        r_d.cnt = r_q.cnt - 4'h1;
        if (r_q.cnt == CNT_RST) begin
          r_d.st = ST_WHIGH;
          r_d.we_b = 1'b1;
          r_d.cnt = 4'(WPH_CYC - 1);
          if (r_q.seq == 2'h3) begin
            r_d.nbytes = r_q.nbytes + 8'h01;
          end
        end
      end
      ST_WHIGH: begin
        r_d.cnt = r_q.cnt - 4'h1;
        if (r_q.cnt == CNT_RST) begin
          r_d.win = WIN_RST;
          if (r_q.seq != 2'h3 && r_q.seq != 2'(PROT_LEN - 1)) begin
            r_d.seq = r_q.seq + 2'h1;
            r_d.addr = seq_addr;
            r_d.wdata = seq_data;
            r_d.st = ST_WLOW;
            r_d.we_b = 1'b0;
            r_d.cnt = 4'(WP_CYC - 1);
          end else begin
            r_d.seq = 2'h3;
            r_d.st = ST_LOAD;
            r_d.ce_b = 1'b1;
            r_d.dq_oe = 1'b0;
            if (r_q.last || r_q.nbytes == 8'(PAGE_BYTES)) begin
              // Page closed by request or full: start polling now
              r_d.st = ST_RHIGH;
              r_d.poll = 1'b1;
              r_d.have_prev = 1'b0;
              r_d.tmo = TMO_RST;
              r_d.cnt = 4'(OEHP_CYC - 1);
            end
          end
        end
      end
      ST_LOAD: begin
        r_d.win = r_q.win + 12'h001;
        if (CMD_VALID && page_ok) begin
          r_d.addr = CMD.addr;
          r_d.wdata = CMD.data;
          r_d.last = CMD.last;
          r_d.st = ST_WLOW;
          r_d.ce_b = 1'b0;
          r_d.we_b = 1'b0;
          r_d.dq_oe = 1'b1;
          r_d.cnt = 4'(WP_CYC - 1);
        end else if (CMD_VALID || r_q.win >= 12'(LOAD_LIM)) begin
          // Window lapses, even with no data after a command
          // sequence, so the device programs what it holds
          r_d.st = ST_RHIGH;
          r_d.poll = 1'b1;
          r_d.have_prev = 1'b0;
          r_d.tmo = TMO_RST;
          r_d.cnt = 4'(OEHP_CYC - 1);
        end
      end
      ST_RLOW: begin
        r_d.cnt = (r_q.cnt == CNT_RST) ? CNT_RST : r_q.cnt - 4'h1;
        // Only settled inputs count: stages two and three agree
        if (r_q.cnt == CNT_RST && r_q.sy2 == r_q.sy3) begin
          r_d.ce_b = 1'b1;
          r_d.oe_b = 1'b1;
          r_d.st = ST_RHIGH;
          r_d.cnt = 4'((r_q.poll ? OEHP_CYC : CEPH_CYC) - 1);
          r_d.have_prev = 1'b1;
          r_d.prev6 = r_q.sy3[6];
          if (!r_q.poll) begin
            r_d.rsp_valid = 1'b1;
            r_d.rsp = '{data: r_q.sy3, err: 1'b0};
            r_d.st = ST_RHIGH;
          end else if (r_q.have_prev && r_q.prev6 == r_q.sy3[6]) begin
            // Two equal toggle reads end programming; start value unknown
            r_d.poll = 1'b0;
            r_d.rsp_valid = 1'b1;
            r_d.rsp = '{data: r_q.sy3, err: 1'b0};
          end else if (r_q.tmo >= 24'(TWC_LIM)) begin
            // Past the longest cycle time the device is done anyway
            r_d.poll = 1'b0;
            r_d.rsp_valid = 1'b1;
            r_d.rsp = '{data: r_q.sy3, err: 1'b1};
          end
        end
      end
      ST_RHIGH: begin
        r_d.cnt = r_q.cnt - 4'h1;
        r_d.ce_b = 1'b1;
        r_d.oe_b = 1'b1;
        if (r_q.cnt == CNT_RST) begin
          if (r_q.poll) begin
            // Fresh strobe each poll, same address every time
            r_d.st = ST_RLOW;
            r_d.ce_b = 1'b0;
            r_d.oe_b = 1'b0;
            r_d.cnt = 4'(ACC_CYC + SYNC_CYC - 1);
          end else begin
            r_d.st = ST_IDLE;
          end
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r_q <= '{st: ST_IDLE, ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1,
               cnt: CNT_RST, win: WIN_RST, tmo: TMO_RST, seq: 2'h3,
               default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Pins float whenever output enable is low; host drives only on writes
  assign PIN = '{addr: r_q.addr, dq: r_q.wdata, dq_oe: r_q.dq_oe,
                 ce_b: r_q.ce_b, oe_b: r_q.oe_b, we_b: r_q.we_b};
  assign RSP_VALID = r_q.rsp_valid;
  assign RSP = r_q.rsp;
  assign BUSY = r_q.st != ST_IDLE;

endmodule : eeprom_host
`default_nettype wire

/* File: bench/eeprom_host_monitor.sv */
// Checker for the paged EEPROM host controller pins and answers
`timescale 1ns/1ns
`default_nettype none
module eeprom_host_monitor (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // Command and answer
  input wire logic CMD_VALID,
  input wire eeprom_host_pkg::cmd_s CMD,
  input wire logic CMD_READY,
  input wire logic RSP_VALID,
  input wire eeprom_host_pkg::rsp_s RSP,
  input wire logic BUSY,
  // Memory pins
  input wire eeprom_host_pkg::pin_out_s PIN,
  input wire logic [7:0] DQ_IN
);
  import eeprom_host_pkg::*;
  logic [9:0] page_q;
  logic [16:0] pa_q;
  logic wr_q;
  logic rd_q;
  logic take_rd;
  logic take_wr;
  logic [10:0] wait_q;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  assign take_rd = CMD_VALID && CMD_READY && !BUSY && CMD.op == OP_READ;
  assign take_wr = CMD_VALID && CMD_READY && !BUSY && CMD.op == OP_WRITE
    && CMD.last;
  // ----------------------------------------------------------------
  // Trackers; the write and read flags clear on each answer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      page_q <= 10'h000;
      pa_q <= 17'h00000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (RSP_VALID) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      if (!PIN.we_b) wr_q <= 1'b1;
      if (!PIN.we_b) page_q <= PIN.addr[16:7];
      if (!PIN.oe_b) rd_q <= 1'b1;
      if (!PIN.oe_b) pa_q <= PIN.addr;
    end
  end
  // Cycles from a one-byte write to its answer; saturates, never wraps
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_q <= 11'h000;
    end else if (RSP_VALID) begin
      wait_q <= 11'h000;
    end else if (take_wr) begin
      wait_q <= 11'h001;
    end else if (wait_q != 11'h000 && wait_q != 11'h7FF) begin
      wait_q <= wait_q + 11'h001;
    end
  end
  wr_strobe_a: assert property (!PIN.we_b |->
    !PIN.ce_b && PIN.oe_b && PIN.dq_oe) else $error("bad write strobe");
  rd_float_a: assert property (!PIN.oe_b |->
    !PIN.dq_oe && PIN.we_b) else $error("host drives during read");
  idle_pins_a: assert property (!BUSY |-> PIN.ce_b && PIN.oe_b &&
    PIN.we_b && !PIN.dq_oe) else $error("pins active while idle");
  // Only read strobes need the gap; page writes may reselect at once
  ce_gap_a: assert property ($rose(PIN.ce_b) && $rose(PIN.oe_b) |=>
    PIN.ce_b) else $error("select high too short");
  rd_lat_a: assert property (take_rd |=> !PIN.ce_b && !PIN.oe_b
    ##[5:40] RSP_VALID) else $error("read answer late");
  wr_done_a: assert property (take_wr |=> !PIN.we_b)
    else $error("write strobe missing");
  wr_late_a: assert property (wait_q <= 11'h4B0)
    else $error("write answer late");
  page_fix_a: assert property ($fell(PIN.we_b) && wr_q |->
    PIN.addr[16:7] == page_q) else $error("page changed in load");
  poll_addr_a: assert property ($fell(PIN.oe_b) && rd_q && wr_q |->
    PIN.addr == pa_q) else $error("poll address moved");
  no_write_a: assert property (rd_q && wr_q |-> PIN.we_b)
    else $error("write during polling");
endmodule : eeprom_host_monitor
bind eeprom_host eeprom_host_monitor mon (.CORE_CLK(CORE_CLK),
  .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
  .RSP_VALID(RSP_VALID), .RSP(RSP), .BUSY(BUSY), .PIN(PIN), .DQ_IN(DQ_IN));
`default_nettype wire

/* File: bench/eeprom_model.sv */
// Behavioural paged EEPROM answering the host controller pins
`timescale 1ns/1ns
`default_nettype none
module eeprom_model #(
  parameter int WIN = eeprom_host_pkg::BLC_CYC,
  parameter int PROG = eeprom_host_pkg::TWC_CYC
) (
  // Timer clock and pins
  input wire logic clk,
  input wire eeprom_host_pkg::pin_out_s pin,
  output logic [7:0] dq_in
);
  import eeprom_host_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] last_q = 8'h00;
  logic [7:0] drv_q = 8'h00;
  logic [7:0] val;
  logic tog_q = 1'b0;
  logic rd_q = 1'b0;
  logic we_q = 1'b1;
  logic rd;
  logic pol;
  int win = 0;
  int busy = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
  assign rd = !pin.ce_b && !pin.oe_b && pin.we_b;
  assign pol = win > 0 || busy > 0;
  assign val = pol ? {~last_q[7], tog_q, last_q[5:0]}
    : mem[pin.addr[7:0]];
  // Released bus shows the inverse, so a stale byte cannot pass
  assign dq_in = pin.dq_oe ? pin.dq : (rd ? val : ~drv_q);
  // ----------------------------------------------------------------
  // Load window and programming timers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_q <= rd;
    we_q <= pin.we_b;
    if (rd) drv_q <= val;
    if (win > 0) win <= win - 1;
    if (busy > 0) busy <= busy - 1;
    if (rd && !rd_q && pol) tog_q <= ~tog_q;
    // A read also ends the load early
    if (win == 1 || (win > 0 && rd && !rd_q)) begin
      win <= 0;
      busy <= PROG;
    end
    if (pin.we_b && !we_q && !pin.ce_b && pin.oe_b && busy == 0) begin
      mem[pin.addr[7:0]] <= pin.dq;
      last_q <= pin.dq;
      win <= WIN;
    end
  end
endmodule : eeprom_model
`default_nettype wire

/* File: bench/test_eeprom_host.sv */
// Self-checking bench for the paged EEPROM host controller
`timescale 1ns/1ns
`default_nettype none
module test_eeprom_host;
  import eeprom_host_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_s cmd = '0;
  logic cmd_ready;
  logic rsp_valid;
  rsp_s rsp;
  logic busy;
  pin_out_s pin;
  logic [7:0] dq_in;
  int err_total = 0;
  int comparisons = 0;
  rsp_s rq[$];
  eeprom_host #(.TWC_LIM(600)) DUT (.CORE_CLK(core_clk), .RST_B(rst_b),
    .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP(rsp), .BUSY(busy), .PIN(pin),
    .DQ_IN(dq_in));
  eeprom_model #(.PROG(100)) MEM (.clk(core_clk), .pin(pin),
    .dq_in(dq_in));
  initial forever #25 core_clk = ~core_clk;
  // Queued so no answer is lost while a command waits
  always @(negedge core_clk) if (rsp_valid === 1'b1) rq.push_back(rsp);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic bail(input string nm);
    err_total++;
    $display("[FAIL] %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask : bail
  task automatic do_reset;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    chk8("idle", 8'h17, {pin.dq_oe, cmd_ready, busy, pin.ce_b, pin.oe_b,
      pin.we_b});
  endtask : do_reset
  task automatic send(input op_e op, input logic [16:0] a,
    input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, d, l};
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) begin
      n++;
      if (n > 5000) bail("ready");
      @(negedge core_clk);
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask : send
  task automatic get(input logic [7:0] e, input logic use_d);
    int n;
    rsp_s r;
    n = 0;
    while (rq.size() == 0) begin
      n++;
      if (n > 8000) bail("answer");
      @(negedge core_clk);
    end
    r = rq.pop_front();
    chk8("err", 8'h00, {7'h00, r.err});
    if (use_d) chk8("data", e, r.data);
  endtask : get
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_byte;
    send(OP_READ, 17'h00040, 8'h00, 1'b0);
    get(8'h7C, 1'b1);
    send(OP_WRITE, 17'h00010, 8'h5A, 1'b1);
    get(8'h00, 1'b0);
    send(OP_READ, 17'h00010, 8'h00, 1'b0);
    get(8'h5A, 1'b1);
  endtask : t_byte
  task automatic t_page;
    for (int i = 0; i < 3; i++) send(OP_WRITE, 17'h00080 + 17'(i),
      8'hA0 + 8'(i), i == 2);
    get(8'h00, 1'b0);
    for (int i = 0; i < 3; i++) begin
      send(OP_READ, 17'h00080 + 17'(i), 8'h00, 1'b0);
      get(8'hA0 + 8'(i), 1'b1);
    end
  endtask : t_page
  task automatic t_window;
    send(OP_WRITE, 17'h00020, 8'h99, 1'b0);
    get(8'h00, 1'b0);
    send(OP_READ, 17'h00020, 8'h00, 1'b0);
    get(8'h99, 1'b1);
  endtask : t_window
  task automatic t_refuse;
    send(OP_WRITE, 17'h001F3, 8'hC3, 1'b0);
    send(OP_READ, 17'h001F3, 8'h00, 1'b0);
    get(8'h00, 1'b0);
    get(8'hC3, 1'b1);
  endtask : t_refuse
  task automatic t_prot;
    send(OP_PROT_ON, 17'h00000, 8'h00, 1'b0);
    send(OP_WRITE, 17'h00005, 8'h6E, 1'b1);
    get(8'h00, 1'b0);
    send(OP_PROT_OFF, 17'h00000, 8'h00, 1'b0);
    get(8'h00, 1'b0);
    send(OP_READ, 17'h00005, 8'h00, 1'b0);
    get(8'h6E, 1'b1);
  endtask : t_prot
  initial begin
    do_reset();
    t_byte();
    t_page();
    t_window();
    t_refuse();
    do_reset();
    t_prot();
    tally_and_finish();
  end
endmodule : test_eeprom_host
`default_nettype wire
